//--- tb/usc_bus_peer.sv
/*
  Behavioural far-side bus device for the serial unit bench: it can clock the
  bus and issue a start condition.
  Assumes open-drain lines with pull-ups, resolved by the bench.
*/
`timescale 1ns/100ps
module usc_bus_peer (
  // Released levels, 1 lets the line float up.
  output logic sda_rel,
  output logic scl_rel
);
  // Both lines start released; the clock stands still outside frames.
  initial begin
    sda_rel = 1'b1;
    scl_rel = 1'b1;
  end

  // Clock pulses with an 80 ns period, twice the 40 ns period of clk/4.
  task automatic pulses(input int n);
    repeat (n) begin
      #40 scl_rel = 1'b0;
      #40 scl_rel = 1'b1;
    end
  endtask

  // Data falls while the clock is high, then the clock is pulled low and let go.
  task automatic start_cond();
    #40 sda_rel = 1'b0;
    #40 scl_rel = 1'b0;
    #40 sda_rel = 1'b1;
    #40 scl_rel = 1'b1;
  endtask
endmodule

//--- tb/usc_top_bench.sv
/*
  Self-checking bench of the serial unit control and status block.
  Assumes the bus peer model and open-drain lines with pull-ups.
*/
`timescale 1ns/100ps
module usc_top_bench import usc_pkg::*; ();
  logic clk, resetn, reg_wr, reg_rd, timer_match, global_irq_enable;
  logic port_sda, port_scl, port_do, ddr_sda, ddr_scl, ddr_do;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
  logic clock_pin_toggle_ff, irq_start_ff, irq_ovf_ff, sda_rel, scl_rel;
  usc_pins_t pins_ff;
  int num_errors, check_count, toggle_seen;
  // Wired-AND lines: a released line goes high through its pull-up.
  wire logic sda_line = sda_rel & ~pins_ff.sda_oe;
  wire logic scl_line = scl_rel & ~pins_ff.scl_oe;

  usc_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .timer_match(timer_match), .global_irq_enable(global_irq_enable),
    .port_sda(port_sda), .port_scl(port_scl), .port_do(port_do), .ddr_sda(ddr_sda),
    .ddr_scl(ddr_scl), .ddr_do(ddr_do), .serial_data_in_pin(sda_line),
    .serial_clock_pin(scl_line), .pins_ff(pins_ff),
    .clock_pin_toggle_ff(clock_pin_toggle_ff), .irq_start_ff(irq_start_ff),
    .irq_ovf_ff(irq_ovf_ff));

  usc_bus_peer peer (.sda_rel(sda_rel), .scl_rel(scl_rel));

  // System clock, 10 ns period.
  always #5 clk = ~clk;

  // Counts toggle requests so a missed or doubled pulse is visible.
  always @(posedge clk) begin
    if (clock_pin_toggle_ff === 1'b1) begin
      toggle_seen++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expect_v);
    check_count++;
    if (seen !== expect_v) begin
      num_errors++;
      $display("BAD at %0t ns seen %h expected %h", $time, seen, expect_v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, input logic [7:0] expect_v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_ff, expect_v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the clock-line pull to reach a level.
  task automatic wait_scl(input logic lvl);
    for (int i = 0; i < 20 && pins_ff.scl_oe !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    check(pins_ff.scl_oe, lvl);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #300000;
    num_errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {reg_wr, reg_rd, timer_match, global_irq_enable} = 4'h0;
    {port_sda, port_scl, port_do, ddr_sda, ddr_scl, ddr_do} = 6'b111000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle(4);
    rd(USC_CTRL_ADDR, 8'h00);
    rd(USC_STAT_ADDR, 8'h10);
    rd(8'hC0, 8'h00);
    check(pins_ff, 16'h0007);
    $display("test reset done");
    // Soft strobes, counter write, wrap and flag clearing.
    wr(USC_DATA_ADDR, 8'hFF);
    wr(USC_STAT_ADDR, 8'h0E);
    rd(USC_STAT_ADDR, 8'h0E);
    wr(USC_CTRL_ADDR, 8'h02);
    rd(USC_STAT_ADDR, 8'h0F);
    rd(USC_CTRL_ADDR, 8'h00);
    wr(USC_CTRL_ADDR, 8'h02);
    rd(USC_STAT_ADDR, 8'h40);
    wr(USC_CTRL_ADDR, 8'h40);
    settle(3);
    check(irq_ovf_ff, 1'b0);
    global_irq_enable <= 1'b1;
    settle(3);
    check(irq_ovf_ff, 1'b1);
    global_irq_enable <= 1'b0;
    wr(USC_STAT_ADDR, 8'h05);
    rd(USC_STAT_ADDR, 8'h45);
    wr(USC_STAT_ADDR, 8'h40);
    rd(USC_STAT_ADDR, 8'h00);
    $display("test soft strobe done");
    // Timer compare matches as counter clock.
    wr(USC_CTRL_ADDR, 8'h04);
    repeat (3) begin
      @(posedge clk);
      timer_match <= 1'b1;
      @(posedge clk);
      timer_match <= 0;
    end
    rd(USC_STAT_ADDR, 8'h03);
    // A counter write meeting a timer event in one cycle keeps the written value.
    @(posedge clk);
    reg_addr <= USC_STAT_ADDR;
    reg_wdata <= 8'h05;
    reg_wr <= 1'b1;
    timer_match <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    timer_match <= 1'b0;
    rd(USC_STAT_ADDR, 8'h05);
    $display("test timer done");
    // External clock counts both edges with outputs disabled.
    wr(USC_CTRL_ADDR, 8'h08);
    peer.pulses(4);
    settle(6);
    rd(USC_STAT_ADDR, 8'h8D);
    // The pending start flag raises its request once both enables are set.
    wr(USC_CTRL_ADDR, 8'h88);
    global_irq_enable <= 1'b1;
    settle(3);
    check(irq_start_ff, 1'b1);
    global_irq_enable <= 1'b0;
    wr(USC_STAT_ADDR, 8'h80);
    rd(USC_STAT_ADDR, 8'h00);
    wr(USC_CTRL_ADDR, 8'h0A);
    wr(USC_CTRL_ADDR, 8'h0B);
    wr(USC_CTRL_ADDR, 8'h0B);
    rd(USC_STAT_ADDR, 8'h02);
    check(16'(toggle_seen), 16'h0002);
    peer.pulses(2);
    settle(6);
    rd(USC_STAT_ADDR, 8'h02);
    $display("test external clock done");
    // Output functions per wire mode.
    wr(USC_CTRL_ADDR, 8'h00);
    settle(3);
    check({pins_ff.do_override, pins_ff.do_oe, pins_ff.sda_oe, pins_ff.scl_oe}, 0);
    ddr_do <= 1'b1;
    wr(USC_CTRL_ADDR, 8'h10);
    settle(3);
    check({pins_ff.do_override, pins_ff.do_oe, pins_ff.sda_oe, pins_ff.scl_oe}, 4'hC);
    wr(USC_CTRL_ADDR, 8'h20);
    ddr_sda <= 1'b1;
    settle(3);
    check({pins_ff.sda_oe, pins_ff.sda_pullup, pins_ff.scl_pullup}, 0);
    port_sda <= 1'b0;
    settle(3);
    check(pins_ff.sda_oe, 1'b1);
    check(pins_ff.scl_oe, 1'b0);
    port_sda <= 1'b1;
    wr(USC_DATA_ADDR, 8'h00);
    settle(3);
    check(pins_ff.sda_oe, 1'b1);
    wr(USC_DATA_ADDR, 8'hFF);
    settle(3);
    check(pins_ff.sda_oe, 1'b0);
    ddr_sda <= 1'b0;
    wr(USC_STAT_ADDR, 8'hE0);
    ddr_scl <= 1'b1;
    port_scl <= 1'b0;
    settle(3);
    check(pins_ff.scl_oe, 1'b1);
    port_scl <= 1'b1;
    settle(3);
    check(pins_ff.scl_oe, 1'b0);
    $display("test wire modes done");
    // Start hold lasts until the start flag is cleared.
    peer.start_cond();
    wait_scl(1'b1);
    settle(20);
    check(pins_ff.scl_oe, 1'b1);
    wr(USC_STAT_ADDR, 8'h80);
    wait_scl(1'b0);
    // Overflow hold in the second two-wire mode.
    wr(USC_STAT_ADDR, 8'h0F);
    wr(USC_CTRL_ADDR, 8'h32);
    wait_scl(1'b1);
    settle(20);
    check(pins_ff.scl_oe, 1'b1);
    wr(USC_STAT_ADDR, 8'h40);
    wait_scl(1'b0);
    $display("test clock hold done");
    results();
  end
endmodule

//--- verilog/usc_bus_cond.sv
/*
  Start and stop condition detector on synchronised data and clock levels.
  Assumes both inputs are already synchronised to clk.
*/
`timescale 1ns/100ps
module usc_bus_cond (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Synchronised lines and detector enable.
  input wire logic sda_s,
  input wire logic scl_s,
  input wire logic en,
  // One-cycle detection pulses.
  output logic start_ff,
  output logic stop_ff
);
  logic sda_d_ff;
  logic scl_d_ff;
  logic nxt_start;
  logic nxt_stop;

  // Data moving while the clock stays high marks a start or a stop.
  always_comb begin
    nxt_start = en & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    nxt_stop = en & scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  end

  // Previous samples and registered pulses.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_d_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      sda_d_ff <= sda_s;
      scl_d_ff <= scl_s;
      start_ff <= nxt_start;
      stop_ff <= nxt_stop;
    end
  end
endmodule

//--- verilog/usc_pkg.sv
/*
  Shared constants and types of the serial unit control and status block:
  register addresses, field positions, reset values and pin control bundle.
  Assumes an 8-bit register port addressed by byte.
*/
package usc_pkg;

  // Register addresses.
  localparam logic [7:0] USC_CTRL_ADDR = 8'hB8;
  localparam logic [7:0] USC_STAT_ADDR = 8'hB9;
  localparam logic [7:0] USC_DATA_ADDR = 8'hBA;

  // Reset values.
  localparam logic [7:0] USC_CTRL_RST = 8'h00;
  localparam logic [7:0] USC_STAT_RST = 8'h00;
  localparam logic [7:0] USC_DATA_RST = 8'h00;

  // Control register field positions.
  localparam int USC_CTRL_SIE = 7;
  localparam int USC_CTRL_OIE = 6;
  localparam int USC_CTRL_WM_LSB = 4;
  localparam int USC_CTRL_CS_LSB = 2;
  localparam int USC_CTRL_CLK = 1;
  localparam int USC_CTRL_TC = 0;

  // Status register field positions.
  localparam int USC_STAT_SIF = 7;
  localparam int USC_STAT_OIF = 6;
  localparam int USC_STAT_PF = 5;
  localparam int USC_STAT_DC = 4;
  localparam int USC_STAT_CNT_LSB = 0;

  // Transfer counter width.
  localparam int USC_CNT_W = 4;

  // Wire modes.
  typedef enum logic [1:0] {
    USC_WM_OFF = 2'h0,
    USC_WM_THREE = 2'h1,
    USC_WM_TWO = 2'h2,
    USC_WM_TWO_OVF = 2'h3
  } usc_wire_mode_t;

  // Clock sources for shift register and counter.
  typedef enum logic [1:0] {
    USC_CS_SOFT = 2'h0,
    USC_CS_TIMER = 2'h1,
    USC_CS_EXT_POS = 2'h2,
    USC_CS_EXT_NEG = 2'h3
  } usc_clk_src_t;

  // Stored control state.
  typedef struct packed {
    logic sie;
    logic oie;
    usc_wire_mode_t wm;
    usc_clk_src_t cs;
    logic clk_sel;
  } usc_ctrl_t;

  // Pin controls handed to the port logic.
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
    logic do_out;
    logic do_oe;
    logic do_override;
    logic sda_pullup;
    logic scl_pullup;
    logic do_pullup;
  } usc_pins_t;

endpackage

//--- verilog/usc_sync.sv
/*
  Two flip-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs change slowly against clk.
*/
`timescale 1ns/100ps
module usc_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Levels in and synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // The first stage feeds the second stage only.
  always_comb begin
    nxt_meta = d;
    nxt_q = meta_ff;
  end

  // Bus lines idle released, so both stages reset high by default.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= RST;
      q_ff <= RST;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end
endmodule

//--- verilog/usc_top.sv
/*
  Control and status of the universal serial unit: transfer counter,
  shift register, flags, interrupt requests and pin control for the
  disabled, three-wire and two-wire modes.
  Assumes a port register block that owns the pins and applies pins_ff,
  a timer compare pulse and global interrupt enable on clk, and bus pins
  arriving asynchronously.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
// How it works
// R01: Collision bit reads one when shift register bit 7 differs from data pin.
// R02: Counter value is visible in status and software can read or overwrite it.
// R03: Counter adds one per clock event from edges, timer match or soft strobe.
// R04: External source with strobe select set: toggle strobe writes clock the counter.
// R05: External clock pin still clocks the counter with wire mode disabled.
// R06: Pending flag with its enable and global enable raises its request at once.
// R07: Wire mode changes outputs, start and stop flag sources and clock hold; sampling and clocking behave alike in all modes.
// R08: Wire mode zero disables outputs, clock hold and start detector.
// R09: Three-wire mode: data output overrides port bit; direction and pull-up as usual.
// R10: Three-wire clock pins stay normal port; software clocks by toggling the port bit.
// R11: Two-wire modes: open-collector data and clock drivers enabled by direction bits.
// R12: Two-wire data line pulled low when shift output or port bit is zero.
// R13: Two-wire clock line pulled low when port bit is zero or a hold demands it.
// R14: Detected start holds the clock line low until the start flag is cleared.
// R15: Two-wire mode disables pull-ups on both bus pins; inputs unaffected.
// R16: Mode three also holds the clock low after overflow until the flag is cleared.
// R17: Overflow flag sets on wrap from fifteen to zero; writing one clears it.
// R18: Start flag clears only by writing one; clearing releases the start hold.
// R19: Soft strobe shifts and counts when selected; strobe bits read as zero.
// R20: Counter write in the same cycle as a clock event keeps the written value.
module usc_top import usc_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Neighbouring on-chip logic.
  input wire logic timer_match,
  input wire logic global_irq_enable,
  // Port and direction bits of the shared pins.
  input wire logic port_sda,
  input wire logic port_scl,
  input wire logic port_do,
  input wire logic ddr_sda,
  input wire logic ddr_scl,
  input wire logic ddr_do,
  // Bus pin levels.
  input wire logic serial_data_in_pin,
  input wire logic serial_clock_pin,
  // Pin controls and requests.
  output usc_pins_t pins_ff,
  output logic clock_pin_toggle_ff,
  output logic irq_start_ff,
  output logic irq_ovf_ff
);
  logic [1:0] pin_s;
  logic sda_s;
  logic scl_s;
  logic start_p;
  logic stop_p;
  logic ctrl_wr;
  logic stat_wr;
  logic data_wr;
  logic two_wire;
  usc_clk_src_t cs_eff;
  logic sel_eff;
  logic ext_src;
  logic scl_rise;
  logic scl_fall;
  logic strobe_wr;
  logic toggle_wr;
  logic shift_ev;
  logic cnt_ev;
  logic change_edge;
  logic ovf_ev;
  logic start_set;
  usc_ctrl_t ctrl_ff;
  usc_ctrl_t nxt_ctrl;
  logic [7:0] nxt_rdata;
  logic [USC_CNT_W-1:0] cnt_ff;
  logic [USC_CNT_W-1:0] nxt_cnt;
  logic [7:0] sr_ff;
  logic [7:0] nxt_sr;
  logic latch_ff;
  logic nxt_latch;
  logic scl_d_ff;
  logic sif_ff;
  logic oif_ff;
  logic pf_ff;
  logic dc_ff;
  logic hold_ff;
  logic nxt_sif;
  logic nxt_oif;
  logic nxt_pf;
  logic nxt_dc;
  logic nxt_hold;
  usc_pins_t nxt_pins;
  logic nxt_toggle;
  logic nxt_irq_start;
  logic nxt_irq_ovf;

  // Bus pins are asynchronous; they pass two stages before any logic.
  usc_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({serial_data_in_pin, serial_clock_pin}),
    .q_ff(pin_s)
  );
  assign sda_s = pin_s[1];
  assign scl_s = pin_s[0];

  // The detector only runs in the two-wire modes.
  usc_bus_cond u_cond (
    .clk(clk),
    .resetn(resetn),
    .sda_s(sda_s),
    .scl_s(scl_s),
    .en(two_wire),
    .start_ff(start_p),
    .stop_ff(stop_p)
  );

  // Decode and clock event selection; a control write acts with its new settings.
  always_comb begin
    ctrl_wr = reg_wr && (reg_addr == USC_CTRL_ADDR);
    stat_wr = reg_wr && (reg_addr == USC_STAT_ADDR);
    data_wr = reg_wr && (reg_addr == USC_DATA_ADDR);
    two_wire = (ctrl_ff.wm == USC_WM_TWO) || (ctrl_ff.wm == USC_WM_TWO_OVF); // see R11
    cs_eff = ctrl_wr ? usc_clk_src_t'(reg_wdata[USC_CTRL_CS_LSB +: 2]) : ctrl_ff.cs;
    sel_eff = ctrl_wr ? reg_wdata[USC_CTRL_CLK] : ctrl_ff.clk_sel;
    ext_src = (cs_eff == USC_CS_EXT_POS) || (cs_eff == USC_CS_EXT_NEG);
    scl_rise = scl_s & ~scl_d_ff;
    scl_fall = ~scl_s & scl_d_ff;
    strobe_wr = ctrl_wr & reg_wdata[USC_CTRL_CLK];
    toggle_wr = ctrl_wr & reg_wdata[USC_CTRL_TC];
    change_edge = (cs_eff == USC_CS_EXT_NEG) ? scl_rise : scl_fall;
    // Pin edges count whatever the wire mode is.
    unique case (cs_eff)
      USC_CS_SOFT: begin
        shift_ev = strobe_wr; // see R19
        cnt_ev = strobe_wr; // see R03
      end
      USC_CS_TIMER: begin
        shift_ev = timer_match;
        cnt_ev = timer_match; // see R03
      end
      USC_CS_EXT_POS: begin
        shift_ev = scl_rise; // see R07
        cnt_ev = sel_eff ? toggle_wr : (scl_rise | scl_fall); // see R04, R05
      end
      USC_CS_EXT_NEG: begin
        shift_ev = scl_fall; // see R07
        cnt_ev = sel_eff ? toggle_wr : (scl_rise | scl_fall); // see R04, R05
      end
    endcase
  end

  // Control register and read data; the read answer lasts one cycle only.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl.sie = reg_wdata[USC_CTRL_SIE];
      nxt_ctrl.oie = reg_wdata[USC_CTRL_OIE];
      nxt_ctrl.wm = usc_wire_mode_t'(reg_wdata[USC_CTRL_WM_LSB +: 2]);
      nxt_ctrl.cs = cs_eff;
      nxt_ctrl.clk_sel = reg_wdata[USC_CTRL_CLK];
    end
    nxt_rdata = 8'h00;
    if (reg_rd && (reg_addr == USC_CTRL_ADDR)) begin
      nxt_rdata = {ctrl_ff.sie, ctrl_ff.oie, ctrl_ff.wm, ctrl_ff.cs, 2'h0}; // see R19
    end else if (reg_rd && (reg_addr == USC_STAT_ADDR)) begin
      nxt_rdata = {sif_ff, oif_ff, pf_ff, dc_ff, cnt_ff}; // see R01, R02
    end else if (reg_rd && (reg_addr == USC_DATA_ADDR)) begin
      nxt_rdata = sr_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= usc_ctrl_t'(USC_CTRL_RST[7:1]);
      reg_rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Counter, shift register and output latch; a software write beats a clock.
  always_comb begin
    nxt_cnt = cnt_ff;
    ovf_ev = 1'b0;
    if (stat_wr) begin
      nxt_cnt = reg_wdata[USC_STAT_CNT_LSB +: USC_CNT_W]; // see R02, R20
    end else if (cnt_ev) begin
      nxt_cnt = cnt_ff + 1'b1; // see R03
      ovf_ev = (cnt_ff == '1); // see R17
    end
    nxt_sr = sr_ff;
    if (data_wr) begin
      nxt_sr = reg_wdata;
    end else if (shift_ev) begin
      nxt_sr = {sr_ff[6:0], sda_s}; // see R19
    end
    // With an external clock the output moves on the edge opposite to sampling.
    nxt_latch = (ext_src && !change_edge) ? latch_ff : nxt_sr[7];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= USC_STAT_RST[USC_STAT_CNT_LSB +: USC_CNT_W];
      sr_ff <= USC_DATA_RST;
      latch_ff <= 1'b0;
      scl_d_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      sr_ff <= nxt_sr;
      latch_ff <= nxt_latch;
      scl_d_ff <= scl_s;
    end
  end

  // Sticky flags; a setting event in the clearing cycle wins.
  always_comb begin
    start_set = (two_wire & start_p) |
                (~two_wire & ext_src & ~sel_eff & (scl_rise | scl_fall));
    nxt_sif = (sif_ff & ~(stat_wr & reg_wdata[USC_STAT_SIF])) | start_set; // see R18
    nxt_oif = (oif_ff & ~(stat_wr & reg_wdata[USC_STAT_OIF])) | ovf_ev; // see R17
    nxt_pf = (pf_ff & ~(stat_wr & reg_wdata[USC_STAT_PF])) | (two_wire & stop_p);
    // Hold starts on a start and ends with the flag clear or leaving two-wire.
    nxt_hold = (two_wire & hold_ff & ~(stat_wr & reg_wdata[USC_STAT_SIF])) |
               (two_wire & start_p); // see R14, R18
    nxt_dc = sr_ff[7] ^ sda_s; // see R01
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sif_ff <= USC_STAT_RST[USC_STAT_SIF];
      oif_ff <= USC_STAT_RST[USC_STAT_OIF];
      pf_ff <= USC_STAT_RST[USC_STAT_PF];
      dc_ff <= USC_STAT_RST[USC_STAT_DC];
      hold_ff <= 1'b0;
    end else begin
      sif_ff <= nxt_sif;
      oif_ff <= nxt_oif;
      pf_ff <= nxt_pf;
      dc_ff <= nxt_dc;
      hold_ff <= nxt_hold;
    end
  end

  // Pin controls; in mode zero every override and driver stays off.
  always_comb begin
    nxt_pins.sda_out = 1'b0; // see R11
    nxt_pins.scl_out = 1'b0; // see R11
    nxt_pins.sda_oe = two_wire & ddr_sda & (~latch_ff | ~port_sda); // see R12
    nxt_pins.scl_oe = two_wire & ddr_scl & (~port_scl | hold_ff |
                      ((ctrl_ff.wm == USC_WM_TWO_OVF) & oif_ff)); // see R13, R16
    nxt_pins.do_override = (ctrl_ff.wm == USC_WM_THREE); // see R08, R09
    nxt_pins.do_out = latch_ff;
    nxt_pins.do_oe = (ctrl_ff.wm == USC_WM_THREE) & ddr_do; // see R09
    nxt_pins.sda_pullup = ~two_wire & ~ddr_sda & port_sda; // see R15
    nxt_pins.scl_pullup = ~two_wire & ~ddr_scl & port_scl; // see R15
    nxt_pins.do_pullup = ~ddr_do & port_do; // see R09
    // The toggle goes to the port bit whatever the mode, for master clocking.
    nxt_toggle = toggle_wr; // see R10
    nxt_irq_start = sif_ff & ctrl_ff.sie & global_irq_enable; // see R06
    nxt_irq_ovf = oif_ff & ctrl_ff.oie & global_irq_enable; // see R06
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_ff <= '0;
      clock_pin_toggle_ff <= 1'b0;
      irq_start_ff <= 1'b0;
      irq_ovf_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      clock_pin_toggle_ff <= nxt_toggle;
      irq_start_ff <= nxt_irq_start;
      irq_ovf_ff <= nxt_irq_ovf;
    end
  end

  // Checks on the counter, flags, reads and pin drive.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_soft_strobe;
    ctrl_wr && (reg_wdata[USC_CTRL_CS_LSB +: 2] == 2'h0) && reg_wdata[USC_CTRL_CLK];
  endsequence

  sequence s_off_settled;
    (ctrl_ff.wm == USC_WM_OFF) [*2];
  endsequence

  a_cnt_event_adds: assert property (cnt_ev && !stat_wr |=> // see R03
    cnt_ff == $past(cnt_ff) + 4'h1) else $error("counter missed an event");
  a_cnt_write_wins: assert property (stat_wr && cnt_ev |=> // see R20
    cnt_ff == $past(reg_wdata[3:0])) else $error("counter write lost");
  a_soft_strobe_counts: assert property (s_soft_strobe |=> // see R19
    cnt_ff == $past(cnt_ff) + 4'h1 && sr_ff[0] == $past(sda_s))
    else $error("soft strobe did not clock");
  a_ovf_on_wrap: assert property (cnt_ev && !stat_wr && cnt_ff == 4'hF |=> // see R17
    oif_ff && cnt_ff == 4'h0) else $error("wrap did not flag overflow");
  a_ovf_stays_set: assert property (oif_ff && !(stat_wr && reg_wdata[6]) |=> // see R17
    oif_ff) else $error("overflow flag dropped without clear");
  a_start_stays_set: assert property (sif_ff && !(stat_wr && reg_wdata[7]) |=> // see R18
    sif_ff) else $error("start flag dropped without clear");
  a_status_read: assert property (reg_rd && reg_addr == USC_STAT_ADDR |=> // see R01
    reg_rdata_ff == {$past(sif_ff), $past(oif_ff), $past(pf_ff), $past(dc_ff), $past(cnt_ff)}
    ##1 ($past(reg_rd) || reg_rdata_ff == 8'h00)) else $error("status read wrong");
  a_ctrl_strobes_zero: assert property (reg_rd && reg_addr == USC_CTRL_ADDR |=> // see R19
    reg_rdata_ff[1:0] == 2'h0) else $error("strobe bits read nonzero");
  a_off_no_drive: assert property (s_off_settled |=> // see R08
    !pins_ff.sda_oe && !pins_ff.scl_oe && !pins_ff.do_override)
    else $error("outputs active with wire mode off");
  a_start_hold_low: assert property (hold_ff && two_wire && ddr_scl |=> // see R14
    pins_ff.scl_oe && !pins_ff.scl_out) else $error("start hold not driving clock low");
  a_sda_pull_low: assert property (two_wire && ddr_sda && !port_sda |=> // see R12
    pins_ff.sda_oe) else $error("data line not pulled low");
  a_ovf_hold_low: assert property (ctrl_ff.wm == USC_WM_TWO_OVF && oif_ff && ddr_scl |=> // see R16
    pins_ff.scl_oe) else $error("overflow hold missing");
  a_irq_pending: assert property (sif_ff && ctrl_ff.sie && global_irq_enable |=> // see R06
    irq_start_ff) else $error("pending start request not raised");
  a_ext_counts_off: assert property (ctrl_ff.cs == USC_CS_EXT_POS && !ctrl_ff.clk_sel && // see R05
    ctrl_ff.wm == USC_WM_OFF && !reg_wr && scl_rise |=> cnt_ff == $past(cnt_ff) + 4'h1)
    else $error("pin edge ignored with outputs off");
endmodule
